// ==== design/pia_adv_reg.sv ====
// Advertisement word storage with strap-loaded speed abilities.
// Assumes straps are stable at and just after reset release.
`timescale 1ns/100ps
`default_nettype none
`include "pia_cfg.svh"

module pia_adv_reg
  import pia_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire pia_strap_t  strap_i,
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_data_i,
  output logic      [15:0] adv_q_o
);

  logic [15:0] adv_q;
  logic [15:0] adv_d;
  logic        strap_loaded_q;
  logic        strap_loaded_d;

  always_comb
  begin
    adv_d          = adv_q;
    strap_loaded_d = 1'b1;
    if (!strap_loaded_q)
    begin
      // Straps are caught by the clock after release, never by the reset
      adv_d[`PIA_ADV_FAST_FD_BIT] = strap_i.fast_fd; // see R14
      adv_d[`PIA_ADV_FAST_HD_BIT] = strap_i.fast_hd; // see R15
      adv_d[`PIA_ADV_TEN_FD_BIT]  = strap_i.ten_fd;  // see R16
      adv_d[`PIA_ADV_TEN_HD_BIT]  = strap_i.ten_hd;  // see R18
    end
    else if (wr_en_i)
    begin
      // Bits 14, 12 and 9 are outside the mask and stay zero
      adv_d = wr_data_i & `PIA_ADV_WR_MASK; // see R6, R7, R8, R9, R13
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      adv_q          <= `PIA_ADV_RESET; // see R19
      strap_loaded_q <= 1'b0;
    end
    else
    begin
      adv_q          <= adv_d; // see R10, R11
      strap_loaded_q <= strap_loaded_d;
    end
  end

  assign adv_q_o = adv_q;

endmodule : pia_adv_reg
`default_nettype wire

// ==== design/pia_cfg.svh ====
// Constants for the identification and advertisement register bank.
// Assumes inclusion by bare name from files under design/.
`ifndef PIA_CFG_SVH
`define PIA_CFG_SVH

// Management register addresses
`define PIA_OFS_BASIC_STATUS  5'h01
`define PIA_OFS_IDENT_HIGH    5'h02
`define PIA_OFS_IDENT_LOW     5'h03
`define PIA_OFS_ADVERTISE     5'h04

// Identification values: arbitrary neutral codes, not a real maker's
`define PIA_ORG_ID_HIGH       16'h5A3C
`define PIA_ORG_ID_LOW        6'h15
`define PIA_VENDOR_MODEL      6'h2A
`define PIA_MODEL_REV         4'h3

// Basic status bit positions
`define PIA_BSW_AN_DONE_BIT   5

// Advertisement bit positions and reset values
`define PIA_ADV_NEXT_PAGE_BIT 15
`define PIA_ADV_RSV14_BIT     14
`define PIA_ADV_REM_FAULT_BIT 13
`define PIA_ADV_RSV12_BIT     12
`define PIA_ADV_ASYM_BIT      11
`define PIA_ADV_PAUSE_BIT     10
`define PIA_ADV_FOUR_PAIR_BIT 9
`define PIA_ADV_FAST_FD_BIT   8
`define PIA_ADV_FAST_HD_BIT   7
`define PIA_ADV_TEN_FD_BIT    6
`define PIA_ADV_TEN_HD_BIT    5
`define PIA_ADV_SEL_MSB       4
`define PIA_ADV_SEL_RESET     5'h01
`define PIA_ADV_WR_MASK       16'hADFF
`define PIA_ADV_RESET         16'h0001

// Management frame timing, counted in management clock edges
`define PIA_PREAMBLE_LEN      6'h20
`define PIA_OP_LEN            6'h02
`define PIA_ADDR_LEN          6'h0A
`define PIA_TA_LEN            6'h02
`define PIA_DATA_LEN          6'h10

// Management opcodes
`define PIA_OP_READ           2'h2
`define PIA_OP_WRITE          2'h1

`endif

// ==== design/pia_pkg.sv ====
// Types shared by the identification and advertisement register bank.
// Assumes nothing of its surroundings.
package pia_pkg;

  typedef enum logic [2:0] {
    PIA_ST_PRE   = 3'b000,
    PIA_ST_START = 3'b001,
    PIA_ST_OP    = 3'b010,
    PIA_ST_ADDR  = 3'b011,
    PIA_ST_TA_RD = 3'b100,
    PIA_ST_RD    = 3'b101,
    PIA_ST_TA_WR = 3'b110,
    PIA_ST_WR    = 3'b111
  } pia_mgmt_state_t;

  typedef struct packed {
    logic fast_fd;
    logic fast_hd;
    logic ten_fd;
    logic ten_hd;
  } pia_strap_t;

  typedef struct packed {
    logic pause;
    logic asym;
  } pia_pause_ability_t;

endpackage : pia_pkg

// ==== design/pia_regs.sv ====
// Management-side identification and advertisement register bank.
// Assumes the management clock and data pin are synchronous to core_clk_i
// and that the management clock is well below half the core rate.
//
// How it works
// R1 - First identifier word returns organisation id bits 3..18, read-only.
// R2 - Second identifier word bits 15:10 return organisation id bits 19..24.
// R3 - Second identifier word bits 9:4 return the vendor model number.
// R4 - Second identifier word bits 3:0 return the model revision.
// R5 - Software renegotiates after advertisement writes made before completion.
// R6 - Advertisement bit 15 is read-write next page request, reset 0.
// R7 - Advertisement bit 14 ignores writes, reads 0.
// R8 - Advertisement bit 13 is read-write remote fault advert, reset 0.
// R9 - Advertisement bit 12 resets and reads 0; software writes only 0.
// R10 - Advertisement bit 11 is read-write asymmetric pause ability, reset 0.
// R11 - Advertisement bit 10 is read-write symmetric pause ability, reset 0.
// R12 - Resolve local and partner pause, report in control bits 13:12; the bank drives pause_resolution_o instead.
// R13 - Advertisement bit 9, four-pair ability, reads 0 always.
// R14 - Advertisement bit 8, fast full duplex, strap reset, read-write.
// R15 - Advertisement bit 7, fast half duplex, strap reset, read-write.
// R16 - Advertisement bit 6, ten full duplex, strap reset, read-write.
// R17 - Basic status bit 5 reads 1 once negotiation has completed.
// R18 - Advertisement bit 5, ten half duplex, strap reset, read-write.
// R19 - Advertisement bits 4:0 are the selector, reset to 00001.
// R20 - Identifier words ignore writes and always return fixed values.
`timescale 1ns/100ps
`default_nettype none
`include "pia_cfg.svh"

module pia_regs
  import pia_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic [4:0]         phy_addr_i,
  input  wire logic               mdc_i,
  input  wire logic               mdio_i,
  output logic                    mdio_o,
  output logic                    mdio_oe_o,
  input  wire pia_strap_t         strap_i,
  input  wire logic               an_complete_i,
  input  wire pia_pause_ability_t partner_pause_i,
  output logic [15:0]             advertise_o,
  output logic [1:0]              pause_resolution_o
);

  pia_mgmt_state_t state_q;
  pia_mgmt_state_t state_d;
  logic [5:0]      cnt_q;
  logic [5:0]      cnt_d;
  logic [1:0]      op_q;
  logic [1:0]      op_d;
  logic [9:0]      addr_q;
  logic [9:0]      addr_d;
  logic [15:0]     shift_q;
  logic [15:0]     shift_d;
  logic            mdio_q;
  logic            mdio_d;
  logic            mdio_oe_q;
  logic            mdio_oe_d;
  logic            mdc_prev_q;
  logic            wr_en_q;
  logic            wr_en_d;
  logic [15:0]     wr_data_q;
  logic [15:0]     wr_data_d;
  logic [1:0]      pause_q;
  logic [1:0]      pause_d;
  logic [15:0]     adv_q;
  logic            mdc_rise;
  logic [9:0]      addr_full;
  logic [15:0]     rd_data;

  // Edge of the management clock, sampled as an ordinary synchronous input
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mdc_prev_q <= 1'b0;
    end
    else
    begin
      mdc_prev_q <= mdc_i;
    end
  end

  assign mdc_rise  = mdc_i & ~mdc_prev_q;
  assign addr_full = {addr_q[8:0], mdio_i};

  // Read data chosen when the register address has fully arrived
  always_comb
  begin
    rd_data = 16'h0000;
    case (addr_full[4:0])
      `PIA_OFS_BASIC_STATUS:
      begin
        // Only completion lives here; other status bits read as zero
        rd_data[`PIA_BSW_AN_DONE_BIT] = an_complete_i; // see R17
      end
      `PIA_OFS_IDENT_HIGH:
      begin
        rd_data = `PIA_ORG_ID_HIGH; // see R1, R20
      end
      `PIA_OFS_IDENT_LOW:
      begin
        rd_data = {`PIA_ORG_ID_LOW, `PIA_VENDOR_MODEL,
                   `PIA_MODEL_REV}; // see R2, R3, R4, R20
      end
      `PIA_OFS_ADVERTISE:
      begin
        rd_data = adv_q;
      end
      default:
      begin
        rd_data = 16'h0000;
      end
    endcase
  end

  // Management frame engine: preamble, start, opcode, addresses,
  // turnaround, then sixteen data bits in either direction
  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    op_d      = op_q;
    addr_d    = addr_q;
    shift_d   = shift_q;
    mdio_d    = mdio_q;
    mdio_oe_d = mdio_oe_q;
    wr_en_d   = 1'b0;
    wr_data_d = wr_data_q;
    if (mdc_rise)
    begin
      case (state_q)
        PIA_ST_PRE:
        begin
          if (mdio_i)
          begin
            if (cnt_q != `PIA_PREAMBLE_LEN)
            begin
              cnt_d = cnt_q + 6'h01;
            end
          end
          else if (cnt_q == `PIA_PREAMBLE_LEN)
          begin
            state_d = PIA_ST_START;
          end
          else
          begin
            cnt_d = 6'h00;
          end
        end
        PIA_ST_START:
        begin
          cnt_d = 6'h00;
          if (mdio_i)
          begin
            state_d = PIA_ST_OP;
          end
          else
          begin
            state_d = PIA_ST_PRE;
          end
        end
        PIA_ST_OP:
        begin
          op_d  = {op_q[0], mdio_i};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == `PIA_OP_LEN - 6'h01)
          begin
            state_d = PIA_ST_ADDR;
            cnt_d   = 6'h00;
          end
        end
        PIA_ST_ADDR:
        begin
          addr_d = addr_full;
          cnt_d  = cnt_q + 6'h01;
          if (cnt_q == `PIA_ADDR_LEN - 6'h01)
          begin
            cnt_d = 6'h00;
            // Frames for another station or with a bad opcode are dropped
            // and a fresh preamble is needed before the next one
            if (addr_full[9:5] != phy_addr_i)
            begin
              state_d = PIA_ST_PRE;
            end
            else if (op_q == `PIA_OP_READ)
            begin
              state_d = PIA_ST_TA_RD;
              shift_d = rd_data;
            end
            else if (op_q == `PIA_OP_WRITE)
            begin
              state_d = PIA_ST_TA_WR;
            end
            else
            begin
              state_d = PIA_ST_PRE;
            end
          end
        end
        PIA_ST_TA_RD:
        begin
          // First turnaround bit is left floating, the second is driven 0
          mdio_d    = 1'b0;
          mdio_oe_d = 1'b1;
          state_d   = PIA_ST_RD;
          cnt_d     = 6'h00;
        end
        PIA_ST_RD:
        begin
          if (cnt_q == `PIA_DATA_LEN)
          begin
            mdio_d    = 1'b0;
            mdio_oe_d = 1'b0;
            state_d   = PIA_ST_PRE;
            cnt_d     = 6'h00;
          end
          else
          begin
            mdio_d  = shift_q[15];
            shift_d = {shift_q[14:0], 1'b0};
            cnt_d   = cnt_q + 6'h01;
          end
        end
        PIA_ST_TA_WR:
        begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == `PIA_TA_LEN - 6'h01)
          begin
            state_d = PIA_ST_WR;
            cnt_d   = 6'h00;
          end
        end
        PIA_ST_WR:
        begin
          shift_d = {shift_q[14:0], mdio_i};
          cnt_d   = cnt_q + 6'h01;
          if (cnt_q == `PIA_DATA_LEN - 6'h01)
          begin
            // Only the advertisement word accepts data; identifier and
            // status writes fall away here
            wr_en_d   = (addr_q[4:0] == `PIA_OFS_ADVERTISE); // see R20
            wr_data_d = {shift_q[14:0], mdio_i};
            state_d   = PIA_ST_PRE;
            cnt_d     = 6'h00;
          end
        end
        default:
        begin
          state_d   = PIA_ST_PRE;
          cnt_d     = 6'h00;
          mdio_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q   <= PIA_ST_PRE;
      cnt_q     <= 6'h00;
      op_q      <= 2'h0;
      addr_q    <= 10'h000;
      shift_q   <= 16'h0000;
      mdio_q    <= 1'b0;
      mdio_oe_q <= 1'b0;
      wr_en_q   <= 1'b0;
      wr_data_q <= 16'h0000;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      op_q      <= op_d;
      addr_q    <= addr_d;
      shift_q   <= shift_d;
      mdio_q    <= mdio_d;
      mdio_oe_q <= mdio_oe_d;
      wr_en_q   <= wr_en_d;
      wr_data_q <= wr_data_d;
    end
  end

  pia_adv_reg u_adv_reg (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .strap_i    (strap_i),
    .wr_en_i    (wr_en_q),
    .wr_data_i  (wr_data_q),
    .adv_q_o    (adv_q)
  );

  // Pause resolution: bit 1 enables sending pause, bit 0 honouring it.
  // Held at zero until negotiation completes, so no stale outcome leaks.
  always_comb
  begin
    pause_d = 2'b00;
    if (an_complete_i)
    begin
      if (adv_q[`PIA_ADV_PAUSE_BIT] && partner_pause_i.pause)
      begin
        pause_d = 2'b11; // see R12
      end
      else if (!adv_q[`PIA_ADV_PAUSE_BIT] && adv_q[`PIA_ADV_ASYM_BIT] &&
               partner_pause_i.pause && partner_pause_i.asym)
      begin
        pause_d = 2'b10; // see R12
      end
      else if (adv_q[`PIA_ADV_PAUSE_BIT] && adv_q[`PIA_ADV_ASYM_BIT] &&
               !partner_pause_i.pause && partner_pause_i.asym)
      begin
        pause_d = 2'b01; // see R12
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pause_q <= 2'b00;
    end
    else
    begin
      pause_q <= pause_d;
    end
  end

  assign mdio_o             = mdio_q;
  assign mdio_oe_o          = mdio_oe_q;
  assign advertise_o        = adv_q;
  assign pause_resolution_o = pause_q;

endmodule : pia_regs
`default_nettype wire

// ==== verif/pia_regs_props.sv ====
// Port assertions for the identification and advertisement bank.
// Assumes binding onto pia_regs; a single core clock domain.
`timescale 1ns/100ps
`default_nettype none
module pia_regs_props
  import pia_pkg::*;
(
  input wire logic               core_clk_i,
  input wire logic               sys_rst_i,
  input wire logic               mdc_i,
  input wire logic               mdio_o,
  input wire logic               mdio_oe_o,
  input wire pia_strap_t         strap_i,
  input wire logic               an_complete_i,
  input wire pia_pause_ability_t partner_pause_i,
  input wire logic [15:0]        advertise_o,
  input wire logic [1:0]         pause_resolution_o
);
  logic       mdc_q;
  logic       mdc_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [1:0] res_w;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Counts management edges while the data pin is driven
  always_comb
  begin
    mdc_d = mdc_i;
    cnt_d = 5'h00;
    if (mdio_oe_o)
      cnt_d = cnt_q + {4'h0, mdc_i & ~mdc_q};
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mdc_q <= 1'b0;
      cnt_q <= 5'h00;
    end
    else
    begin
      mdc_q <= mdc_d;
      cnt_q <= cnt_d;
    end
  end

  assign res_w = !an_complete_i ? 2'h0 :
    (advertise_o[10] & partner_pause_i.pause) ? 2'h3 :
    (!advertise_o[10] & advertise_o[11] & partner_pause_i.pause
      & partner_pause_i.asym) ? 2'h2 :
    (advertise_o[10] & advertise_o[11] & !partner_pause_i.pause
      & partner_pause_i.asym) ? 2'h1 : 2'h0;

  sequence s_ta_low;
    ##1 !mdio_o;
  endsequence
  sequence s_strap_word;
    advertise_o == {7'h00, $past(strap_i), 5'h01};
  endsequence

  adv_rsvd_a: assert property (
    !advertise_o[14] && !advertise_o[12] && !advertise_o[9])
    else $error("reserved advertisement bit set");
  strap_load_a: assert property (
    $fell(sys_rst_i) |=> s_strap_word)
    else $error("advertisement not loaded from straps");
  pause_res_a: assert property (
    1'b1 |=> pause_resolution_o == $past(res_w))
    else $error("pause resolution wrong");
  ta_low_a: assert property ($rose(mdio_oe_o) |-> s_ta_low)
    else $error("turnaround bit not low");
  oe_len_a: assert property ($fell(mdio_oe_o) |-> cnt_q == 5'h11)
    else $error("read drive length wrong");
  mdio_edge_a: assert property ($changed(mdio_o) |-> $past(mdc_i))
    else $error("data out moved away from clock edge");
  oe_edge_a: assert property ($changed(mdio_oe_o) |-> $past(mdc_i))
    else $error("drive enable moved away from clock edge");
  adv_write_a: assert property (
    $changed(advertise_o) && !$past(sys_rst_i, 2) |-> $past(mdc_i))
    else $error("advertisement changed without a write");
endmodule : pia_regs_props
`default_nettype wire

// ==== verif/pia_sta.sv ====
// Station management model issuing whole frames to the bank.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/100ps
`default_nettype none
`include "pia_cfg.svh"
module pia_sta
  import pia_pkg::*;
#(
  parameter int HALF = 4
)
(
  input  wire logic core_clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  initial
  begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // Clock stands low between frames; data moves only while it is low.
  // No renegotiation is requested: the bank has no pin for it
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] f;
    f  = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge core_clk_i);
      #1;
      mdc_o     = 1'b0;
      mdio_oe_o = !(op == `PIA_OP_READ && i >= 46);
      mdio_o    = f[63-i];
      repeat (HALF - 1) @(posedge core_clk_i);
      #1;
      if (i >= 48)
        rd = {rd[14:0], mdio_i};
      mdc_o = 1'b1;
      repeat (HALF - 1) @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
    #1;
    mdc_o     = 1'b0;
    mdio_oe_o = 1'b0;
  endtask : xfer
endmodule : pia_sta
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the identification and advertisement bank.
// Assumes pia_regs, pia_regs_props and pia_sta are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "pia_cfg.svh"
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module tb
  import pia_pkg::*;
;
  logic               core_clk_i;
  logic               sys_rst_i;
  logic [4:0]         phy_addr_i;
  logic               mdc;
  logic               mdio_line;
  logic               dut_do;
  logic               dut_oe;
  logic               sta_do;
  logic               sta_oe;
  pia_strap_t         strap_i;
  logic               an_complete_i;
  pia_pause_ability_t partner_pause_i;
  logic [15:0]        advertise_o;
  logic [1:0]         pause_resolution_o;
  logic [15:0]        rdv;
  int                 n_errors = 0;
  int                 checked = 0;

  initial core_clk_i = 1'b0;
  always #5 core_clk_i = ~core_clk_i;

  // Pull-up on the shared data line when nobody drives it
  assign mdio_line = dut_oe ? dut_do : (sta_oe ? sta_do : 1'b1);

  pia_regs i_dut (
    .core_clk_i,
    .sys_rst_i,
    .phy_addr_i,
    .mdc_i     (mdc),
    .mdio_i    (mdio_line),
    .mdio_o    (dut_do),
    .mdio_oe_o (dut_oe),
    .strap_i,
    .an_complete_i,
    .partner_pause_i,
    .advertise_o,
    .pause_resolution_o
  );
  pia_sta i_sta (
    .core_clk_i,
    .mdio_i    (mdio_line),
    .mdc_o     (mdc),
    .mdio_o    (sta_do),
    .mdio_oe_o (sta_oe)
  );

  function automatic logic [1:0] pres(input logic [1:0] l,
                                      input logic [1:0] p);
    if (l[0] && p[1])
      return 2'h3;
    if (!l[0] && l[1] && p[1] && p[0])
      return 2'h2;
    if (l[0] && l[1] && !p[1] && p[0])
      return 2'h1;
    return 2'h0;
  endfunction : pres

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    i_sta.xfer(`PIA_OP_READ, 5'h05, ra, 16'h0000, v);
    `CHK(v, exp)
  endtask : rd

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] v;
    i_sta.xfer(`PIA_OP_WRITE, 5'h05, ra, d, v);
  endtask : wr

  task automatic conclude();
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    #500000;
    n_errors++;
    conclude();
  end

  initial
  begin
    sys_rst_i       = 1'b1;
    phy_addr_i      = 5'h05;
    strap_i         = 4'hA;
    an_complete_i   = 1'b0;
    partner_pause_i = 2'h0;
    repeat (5) @(posedge core_clk_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    rd(5'h04, 16'h0141);
    rd(5'h02, `PIA_ORG_ID_HIGH);
    wr(5'h02, 16'h0000);
    wr(5'h03, 16'h0000);
    rd(5'h02, `PIA_ORG_ID_HIGH);
    rd(5'h03, {`PIA_ORG_ID_LOW, `PIA_VENDOR_MODEL,
               `PIA_MODEL_REV});
    // Software keeps bit 12 at zero; every other bit is tried with a one
    wr(5'h04, 16'hEFFF);
    `CHK(advertise_o, 16'hADFF)
    rd(5'h04, 16'hADFF);
    wr(5'h04, 16'h4A5A);
    rd(5'h04, 16'h085A);
    // Opcode 11 is refused, so the word must stay as last written
    i_sta.xfer(2'h3, 5'h05, 5'h04, 16'hFFFF, rdv);
    `CHK(advertise_o, 16'h085A)
    rd(5'h01, 16'h0000);
    rd(5'h1F, 16'h0000);
    i_sta.xfer(`PIA_OP_READ, 5'h06, 5'h02, 16'h0000, rdv);
    `CHK(rdv, 16'hFFFF)
    // Completion here stands for the renegotiation after the early writes
    an_complete_i = 1'b1;
    rd(5'h01, 16'h0020);
    for (int l = 0; l < 4; l++)
    begin
      wr(5'h04, {4'h0, l[1:0], 10'h000});
      `CHK(advertise_o, {4'h0, l[1:0], 10'h000})
      for (int p = 0; p < 4; p++)
      begin
        partner_pause_i = p[1:0];
        repeat (2) @(posedge core_clk_i);
        #1;
        `CHK(pause_resolution_o, pres(l[1:0], p[1:0]))
      end
    end
    an_complete_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK(pause_resolution_o, 2'h0)
    sys_rst_i = 1'b1;
    strap_i   = 4'h5;
    repeat (5) @(posedge core_clk_i);
    #1;
    `CHK(advertise_o, 16'h0001)
    sys_rst_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK(advertise_o, 16'h00A1)
    rd(5'h04, 16'h00A1);
    conclude();
  end
endmodule : tb

bind pia_regs pia_regs_props i_props (
  .core_clk_i,
  .sys_rst_i,
  .mdc_i,
  .mdio_o,
  .mdio_oe_o,
  .strap_i,
  .an_complete_i,
  .partner_pause_i,
  .advertise_o,
  .pause_resolution_o
);
`default_nettype wire
